// >>> rtl/fpdc_pkg.sv
// constants shared by the flash download controller and its copy engine
// assumes a 32-bit AXI4-Lite register bus and 24-bit cpu vector addresses
package fpdc_pkg;

	// ***************************************************************
	// register byte offsets
	// ***************************************************************
	localparam logic [7:0] CODE_CONTROL_STATUS_OFF    = 8'h00;
	localparam logic [7:0] PROGRAM_ROUTINE_SELECT_OFF = 8'h04;
	localparam logic [7:0] ERASE_ROUTINE_SELECT_OFF   = 8'h08;
	localparam logic [7:0] DOWNLOAD_DEST_ADDR_OFF     = 8'h0c;
	localparam logic [7:0] KEY_CODE_REG_OFF           = 8'h10;
	localparam logic [7:0] DOWNLOAD_STATUS_OFF        = 8'h14;

	// ***************************************************************
	// field positions, masks and reset values
	// ***************************************************************
	localparam int         RELOCATE_BIT     = 3;
	localparam int         REQUEST_BIT      = 0;
	localparam int         SELECT_BIT       = 0;
	localparam int         BUSY_BIT         = 0;
	localparam logic [7:0] CCS_STORE_MASK   = 8'h6e;
	localparam logic [7:0] CCS_RESET        = 8'h00;
	localparam logic [7:0] SELECT_RESET     = 8'h00;
	localparam logic [7:0] DEST_RESET       = 8'h00;
	localparam logic [7:0] KEY_RESET        = 8'h00;
	localparam logic [7:0] KEY_DOWNLOAD     = 8'ha5;

	// ***************************************************************
	// vector relocation window
	// ***************************************************************
	localparam logic [23:0] VEC_LOW_LAST    = 24'h00007f;
	localparam logic [23:0] VEC_RAM_FIRST   = 24'hffe080;
	localparam logic [23:0] VEC_RAM_LAST    = 24'hffe0ff;

	// ***************************************************************
	// bus answers
	// ***************************************************************
	localparam logic [1:0] RESP_OKAY        = 2'b00;
	localparam logic [1:0] RESP_SLVERR      = 2'b10;

	typedef enum logic [2:0] {
		FPDC_SEL_CCS  = 3'b000,
		FPDC_SEL_PRG  = 3'b001,
		FPDC_SEL_ERS  = 3'b010,
		FPDC_SEL_DEST = 3'b011,
		FPDC_SEL_KEY  = 3'b100,
		FPDC_SEL_STAT = 3'b101,
		FPDC_SEL_NONE = 3'b111
	} fpdc_sel_t;

	typedef enum logic [1:0] {
		FPDC_IDLE   = 2'b00,
		FPDC_FETCH  = 2'b01,
		FPDC_STORE  = 2'b10,
		FPDC_FINISH = 2'b11
	} fpdc_copy_state_t;

endpackage

// >>> rtl/fpdc_copy_if.sv
// request and answer between the register block and the copy engine
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface fpdc_copy_if;
	logic       start;
	logic       use_program;
	logic       use_erase;
	logic [7:0] dest;
	logic       busy;
	logic       done;

	modport ctrl (output start, output use_program, output use_erase,
		output dest, input busy, input done);
	modport engine (input start, input use_program, input use_erase,
		input dest, output busy, output done);
endinterface
`default_nettype wire

// >>> rtl/fpdc_copy_engine.sv
// copy engine: moves one built-in routine from rom into on-chip ram
// assumes a rom with one cycle read latency and a plain ram write port
`timescale 1ns/1ps
`default_nettype none
module fpdc_copy_engine
	import fpdc_pkg::*;
#(
	parameter int ROUTINE_WORDS = 16,
	parameter int IDX_W         = 4,
	parameter int DW            = 32
) (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	fpdc_copy_if.engine               cmd,
	output logic [IDX_W:0]            rom_addr,
	input  wire logic [DW-1:0]        rom_data,
	output logic                      ram_we,
	output logic [IDX_W+7:0]          ram_addr,
	output logic [DW-1:0]             ram_wdata
);

	generate
		if (ROUTINE_WORDS < 1 || ROUTINE_WORDS > (1 << IDX_W)) begin : g_chk
			$error("fpdc_copy_engine: ROUTINE_WORDS does not fit IDX_W");
		end
	endgenerate

	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(ROUTINE_WORDS - 1);

	typedef struct packed {
		fpdc_copy_state_t st;
		logic             erase;
		logic [7:0]       dest;
		logic [IDX_W-1:0] idx;
		logic             we;
		logic [IDX_W+7:0] waddr;
		logic [DW-1:0]    wdata;
		logic             done;
	} fpdc_eng_t;

	fpdc_eng_t s_reg;
	fpdc_eng_t s_next;

	// ***************************************************************
	// sequence
	// ***************************************************************
	always_comb begin
		s_next      = s_reg;
		s_next.we   = 1'b0;
		s_next.done = 1'b0;
		case (s_reg.st)
			FPDC_IDLE: begin
				if (cmd.start) begin // [R6]
					s_next.erase = ~cmd.use_program;
					s_next.dest  = cmd.dest;
					s_next.idx   = '0;
					// nothing selected: finish without touching ram
					if (cmd.use_program || cmd.use_erase) begin
						s_next.st = FPDC_FETCH;
					end else begin
						s_next.st = FPDC_FINISH;
					end
				end
			end
			FPDC_FETCH: begin
				s_next.st = FPDC_STORE;
			end
			FPDC_STORE: begin
				s_next.we    = 1'b1; // [R6]
				s_next.waddr = {s_reg.dest, s_reg.idx};
				s_next.wdata = rom_data;
				s_next.idx   = s_reg.idx + 1'b1;
				if (s_reg.idx == LAST_IDX) begin
					s_next.st = FPDC_FINISH;
				end else begin
					s_next.st = FPDC_FETCH;
				end
			end
			FPDC_FINISH: begin
				s_next.done = 1'b1; // [R9] [R12] [R15]
				s_next.st   = FPDC_IDLE;
			end
			default: begin
				s_next.st = FPDC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rom_addr  = {s_reg.erase, s_reg.idx};
	assign ram_we    = s_reg.we;
	assign ram_addr  = s_reg.waddr;
	assign ram_wdata = s_reg.wdata;
	assign cmd.done  = s_reg.done;
	assign cmd.busy  = (s_reg.st != FPDC_IDLE);

endmodule
`default_nettype wire

// >>> rtl/fpdc_top.sv
// flash program download control: register block over AXI4-Lite,
// interrupt vector relocation and the routine download request
// assumes the cpu flags execution from on-chip ram on exec_from_ram
// and presents each vector fetch address on vec_req / vec_addr
//
// Notes on behaviour
// R1: relocate bit set moves vector fetches 000000-00007f to ffe080-ffe0ff.
// R2: vectors 0 to 31 stay serviceable from ram while flash is busy.
// R3: software avoids vectors 32 and up while relocating; not remapped.
// R4: software fills the ram vector table before setting relocate.
// R5: relocate clear leaves vectors alone; software masks interrupts.
// R6: a download request copies the selected routine to the destination.
// R7: request accepted only with key a5 and execution from ram.
// R8: software runs four no-ops after requesting a download.
// R9: request bit clears at copy end; it always reads zero.
// R10: software keeps interrupts disabled during a download.
// R11: program select bit 0 picks the programming routine; resets zero.
// R12: program select clears itself when the copy completes.
// R13: software keeps reserved bits at zero.
// R14: relocate bit is bit 3, read/write, reset zero.
// R15: erase select bit picks the erase routine; clears at copy end.
// R16: software loads the destination before requesting a download.
// R17: a refused request changes no select, destination or ram.
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fpdc_top
	import fpdc_pkg::*;
#(
	parameter int AW            = 8,
	parameter int ROUTINE_WORDS = 16,
	parameter int IDX_W         = 4
) (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	// axi4-lite slave
	input  wire logic [AW-1:0]        s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [AW-1:0]        s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// cpu side
	input  wire logic                 exec_from_ram,
	input  wire logic                 vec_req,
	input  wire logic [23:0]          vec_addr,
	output logic                      vec_valid_out,
	output logic [23:0]               vec_addr_out,
	output logic                      vector_relocate_enable,
	// routine rom and on-chip ram
	output logic [IDX_W:0]            rom_addr,
	input  wire logic [31:0]          rom_data,
	output logic                      ram_we,
	output logic [IDX_W+7:0]          ram_addr,
	output logic [31:0]               ram_wdata,
	output logic                      download_busy
);

	generate
		if (AW < 8) begin : g_chk
			$error("fpdc_top: AW must cover the register map");
		end
	endgenerate

	// ***************************************************************
	// address decode, shared by both bus paths
	// ***************************************************************
	function automatic fpdc_sel_t reg_sel(input logic [AW-1:0] a);
		fpdc_sel_t r;
		r = FPDC_SEL_NONE;
		if ((a >> 8) == '0) begin
			case (a[7:0])
				CODE_CONTROL_STATUS_OFF:    r = FPDC_SEL_CCS;
				PROGRAM_ROUTINE_SELECT_OFF: r = FPDC_SEL_PRG;
				ERASE_ROUTINE_SELECT_OFF:   r = FPDC_SEL_ERS;
				DOWNLOAD_DEST_ADDR_OFF:     r = FPDC_SEL_DEST;
				KEY_CODE_REG_OFF:           r = FPDC_SEL_KEY;
				DOWNLOAD_STATUS_OFF:        r = FPDC_SEL_STAT;
				default:                    r = FPDC_SEL_NONE;
			endcase
		end
		return r;
	endfunction

	// ***************************************************************
	// state
	// ***************************************************************
	typedef struct packed {
		logic          aw_held;
		logic [AW-1:0] aw_addr;
		logic          w_held;
		logic [31:0]   w_data;
		logic [3:0]    w_strb;
		logic          bvalid;
		logic [1:0]    bresp;
		logic          rvalid;
		logic [31:0]   rdata;
		logic [1:0]    rresp;
		logic [7:0]    code_control_status;
		logic [7:0]    program_routine_select;
		logic [7:0]    erase_routine_select;
		logic [7:0]    download_dest_addr;
		logic [7:0]    key_code_reg;
		logic          start;
		logic          vec_valid;
		logic [23:0]   vec_out;
	} fpdc_state_t;

	fpdc_state_t s_reg;
	fpdc_state_t s_next;

	fpdc_copy_if copy_bus ();

	logic      wr_go;
	logic      rd_go;
	fpdc_sel_t wr_sel;
	fpdc_sel_t rd_sel;
	logic      wr_lane0;
	logic      req_ok;

	assign s_axi_awready = ~s_reg.aw_held & ~s_reg.bvalid;
	assign s_axi_wready  = ~s_reg.w_held & ~s_reg.bvalid;
	assign s_axi_arready = ~s_reg.rvalid;

	// one write at a time: both halves held, previous answer gone
	assign wr_go    = s_reg.aw_held & s_reg.w_held & ~s_reg.bvalid;
	assign rd_go    = s_axi_arvalid & ~s_reg.rvalid;
	assign wr_sel   = reg_sel(s_reg.aw_addr);
	assign rd_sel   = reg_sel(s_axi_araddr);
	assign wr_lane0 = s_reg.w_strb[0];

	// key and ram execution both checked at the moment of the write
	assign req_ok = (s_reg.key_code_reg == KEY_DOWNLOAD) &
		exec_from_ram & ~copy_bus.busy; // [R7]

	// ***************************************************************
	// next state
	// ***************************************************************
	always_comb begin
		s_next       = s_reg;
		s_next.start = 1'b0;

		// write address and data are taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_next.aw_held = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_next.w_held = 1'b1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end

		// copy end clears both selects; a write below may set again
		if (copy_bus.done) begin
			s_next.program_routine_select[SELECT_BIT] = 1'b0; // [R12]
			s_next.erase_routine_select[SELECT_BIT]   = 1'b0; // [R15]
		end

		if (wr_go) begin
			s_next.aw_held = 1'b0;
			s_next.w_held  = 1'b0;
			s_next.bvalid  = 1'b1;
			s_next.bresp   = RESP_OKAY;
			if (wr_sel == FPDC_SEL_NONE) begin
				s_next.bresp = RESP_SLVERR;
			end else if (wr_lane0) begin
				case (wr_sel)
					FPDC_SEL_CCS: begin
						// request bit is never stored, so it reads zero
						s_next.code_control_status =
							s_reg.w_data[7:0] & CCS_STORE_MASK; // [R14] [R9]
						if (s_reg.w_data[REQUEST_BIT] && req_ok) begin
							s_next.start = 1'b1; // [R6] [R7]
						end
					end
					FPDC_SEL_PRG: begin
						s_next.program_routine_select =
							s_reg.w_data[7:0]; // [R11]
					end
					FPDC_SEL_ERS: begin
						s_next.erase_routine_select =
							s_reg.w_data[7:0]; // [R15]
					end
					FPDC_SEL_DEST: begin
						s_next.download_dest_addr = s_reg.w_data[7:0];
					end
					FPDC_SEL_KEY: begin
						s_next.key_code_reg = s_reg.w_data[7:0];
					end
					default: begin
					end
				endcase
			end
		end

		// reads answer one cycle after the address is taken
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (rd_go) begin
			s_next.rvalid = 1'b1;
			s_next.rresp  = RESP_OKAY;
			s_next.rdata  = '0;
			case (rd_sel)
				FPDC_SEL_CCS: begin
					s_next.rdata[7:0] = s_reg.code_control_status; // [R9]
				end
				FPDC_SEL_PRG: begin
					s_next.rdata[7:0] = s_reg.program_routine_select;
				end
				FPDC_SEL_ERS: begin
					s_next.rdata[7:0] = s_reg.erase_routine_select;
				end
				FPDC_SEL_DEST: begin
					s_next.rdata[7:0] = s_reg.download_dest_addr;
				end
				FPDC_SEL_KEY: begin
					s_next.rdata[7:0] = s_reg.key_code_reg;
				end
				FPDC_SEL_STAT: begin
					s_next.rdata[BUSY_BIT] = copy_bus.busy;
				end
				default: begin
					s_next.rresp = RESP_SLVERR;
				end
			endcase
		end

		// vector fetch: low table moves into the ram window
		s_next.vec_valid = vec_req;
		s_next.vec_out   = vec_addr;
		if (vec_req && s_reg.code_control_status[RELOCATE_BIT] &&
			vec_addr <= VEC_LOW_LAST) begin
			// vectors 32 and up are beyond the window and pass unchanged
			s_next.vec_out = VEC_RAM_FIRST + vec_addr; // [R1] [R2] [R3]
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_reg                        <= '0;
			s_reg.code_control_status    <= CCS_RESET; // [R14]
			s_reg.program_routine_select <= SELECT_RESET; // [R11]
			s_reg.erase_routine_select   <= SELECT_RESET;
			s_reg.download_dest_addr     <= DEST_RESET;
			s_reg.key_code_reg           <= KEY_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// ***************************************************************
	// copy engine
	// ***************************************************************
	// a refused request raises no start, so nothing moves
	assign copy_bus.start       = s_reg.start; // [R17]
	assign copy_bus.use_program =
		s_reg.program_routine_select[SELECT_BIT]; // [R11]
	assign copy_bus.use_erase   = s_reg.erase_routine_select[SELECT_BIT];
	assign copy_bus.dest        = s_reg.download_dest_addr;

	fpdc_copy_engine #(
		.ROUTINE_WORDS (ROUTINE_WORDS),
		.IDX_W         (IDX_W),
		.DW            (32)
	) u_engine (
		.clk       (clk),
		.rstn      (rstn),
		.cmd       (copy_bus),
		.rom_addr  (rom_addr),
		.rom_data  (rom_data),
		.ram_we    (ram_we),
		.ram_addr  (ram_addr),
		.ram_wdata (ram_wdata)
	);

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign s_axi_bvalid           = s_reg.bvalid;
	assign s_axi_bresp            = s_reg.bresp;
	assign s_axi_rvalid           = s_reg.rvalid;
	assign s_axi_rdata            = s_reg.rdata;
	assign s_axi_rresp            = s_reg.rresp;
	assign vec_valid_out          = s_reg.vec_valid;
	assign vec_addr_out           = s_reg.vec_out;
	assign vector_relocate_enable =
		s_reg.code_control_status[RELOCATE_BIT]; // [R1]
	assign download_busy          = copy_bus.busy;

endmodule
`default_nettype wire

// >>> tb/fpdc_monitor.sv
// checker for the flash download controller top module
// assumes bench traffic issues one bus access at a time
`timescale 1ns/1ps
`default_nettype none
module fpdc_monitor
	import fpdc_pkg::*;
#(
	parameter int AW            = 8,
	parameter int ROUTINE_WORDS = 16,
	parameter int IDX_W         = 4
) (
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic [AW-1:0]     s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic [31:0]       s_axi_wdata,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic [AW-1:0]     s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              exec_from_ram,
	input wire logic              vec_req,
	input wire logic [23:0]       vec_addr,
	input wire logic              vec_valid_out,
	input wire logic [23:0]       vec_addr_out,
	input wire logic              vector_relocate_enable,
	input wire logic              ram_we,
	input wire logic [IDX_W+7:0]  ram_addr,
	input wire logic              download_busy
);
	// ************************************************
	// helper state
	// ************************************************
	// fetch and store per word, one finish cycle
	localparam int SPAN = 2 * ROUTINE_WORDS + 1;
	logic [AW-1:0] ar_reg;
	logic [7:0]    bcnt_reg;

	// busy run length, read when busy falls
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ar_reg   <= '0;
			bcnt_reg <= 8'h00;
		end else begin
			if (s_axi_arvalid && s_axi_arready)
				ar_reg <= s_axi_araddr;
			bcnt_reg <= download_busy ? bcnt_reg + 8'h01 : 8'h00;
		end
	end

	// ************************************************
	// properties
	// ************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_two_words;
		ram_we ##2 ram_we;
	endsequence

	a_write_resp: assert property (s_wtake |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer late or early");
	a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	a_req_zero: assert property (s_axi_rvalid && ar_reg == '0 |-> !s_axi_rdata[0])
		else $error("request bit read as one");
	a_reloc_mirror: assert property (s_axi_rvalid && ar_reg == '0
		|-> s_axi_rdata[3] == vector_relocate_enable)
		else $error("relocate bit and output differ");
	a_vec_remap: assert property (vec_req && vector_relocate_enable
		&& vec_addr <= VEC_LOW_LAST |=> vec_valid_out
		&& vec_addr_out == $past(vec_addr) + VEC_RAM_FIRST)
		else $error("vector not moved to ram window");
	a_vec_pass: assert property (vec_req && !(vector_relocate_enable
		&& vec_addr <= VEC_LOW_LAST) |=> vec_valid_out
		&& vec_addr_out == $past(vec_addr))
		else $error("vector moved without cause");
	a_busy_span: assert property ($fell(download_busy)
		|-> bcnt_reg == 8'(SPAN) || bcnt_reg == 8'h01)
		else $error("copy length wrong");
	a_ram_step: assert property (s_two_words
		|-> ram_addr == $past(ram_addr, 2) + 1'b1)
		else $error("ram address not stepping");
	a_we_in_copy: assert property (ram_we
		|-> download_busy || $past(download_busy))
		else $error("ram written outside copy");
	a_req_refused: assert property (s_wtake and (s_axi_awaddr == '0
		&& s_axi_wdata[0] && !exec_from_ram && !download_busy)
		|-> !download_busy [*4])
		else $error("download started outside ram");
endmodule

bind fpdc_top fpdc_monitor #(.AW(AW), .ROUTINE_WORDS(ROUTINE_WORDS),
	.IDX_W(IDX_W)) u_mon (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .exec_from_ram, .vec_req, .vec_addr,
	.vec_valid_out, .vec_addr_out, .vector_relocate_enable, .ram_we,
	.ram_addr, .download_busy);
`default_nettype wire

// >>> tb/fpdc_mem_model.sv
// routine rom and on-chip ram standing beside the controller
// assumes rom read latency of one clock
`timescale 1ns/1ps
`default_nettype none
module fpdc_mem_model #(
	parameter int IDX_W = 4
) (
	input  wire logic              clk,
	input  wire logic [IDX_W:0]    rom_addr,
	output var  logic [31:0]       rom_data,
	input  wire logic              ram_we,
	input  wire logic [IDX_W+7:0]  ram_addr,
	input  wire logic [31:0]       ram_wdata
);
	logic [31:0] ram [0:(1<<(IDX_W+8))-1];
	int          n_wr = 0;

	// word content names its own index, so a swap shows up
	always @(posedge clk) begin
		rom_data <= 32'hc0de0000 | 32'(rom_addr);
		if (ram_we) begin
			ram[ram_addr] <= ram_wdata;
			n_wr++;
		end
	end
endmodule
`default_nettype wire

// >>> tb/flash_program_download_ctrl_bench.sv
// self-checking bench for the flash download controller
// assumes the partner memory model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module flash_program_download_ctrl_bench;
	import fpdc_pkg::*;
	logic        clk = 0, rstn = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rom_data, ram_wdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, vec_valid_out, vector_relocate_enable;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        exec_from_ram = 0, vec_req = 0, ram_we, download_busy;
	logic [23:0] vec_addr = 0, vec_addr_out;
	logic [4:0]  rom_addr;
	logic [11:0] ram_addr;
	logic [31:0] d;
	logic [1:0]  r, b;
	int          mismatches = 0, n_compared = 0, i, k;

	always #20 clk = ~clk;

	fpdc_top dut (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .exec_from_ram,
		.vec_req, .vec_addr, .vec_valid_out, .vec_addr_out,
		.vector_relocate_enable, .rom_addr, .rom_data, .ram_we,
		.ram_addr, .ram_wdata, .download_busy);
	fpdc_mem_model mem (.clk, .rom_addr, .rom_data, .ram_we, .ram_addr,
		.ram_wdata);

	// ************************************************
	// tasks
	// ************************************************
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic tmo(input int n);
		if (n >= 100) begin
			mismatches++;
			wrap_up;
		end
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		b = s_axi_bresp;
		s_axi_bready <= 0;
		tmo(n);
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
		tmo(n);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(d, exp);
	endtask

	task automatic vchk(input logic [23:0] a, input logic [23:0] exp);
		@(posedge clk);
		vec_req <= 1;
		vec_addr <= a;
		@(posedge clk);
		vec_req <= 0;
		#1;
		chk(32'(vec_valid_out), 1);
		chk(32'(vec_addr_out), 32'(exp));
	endtask

	task automatic idle_wait;
		int n;
		for (n = 0; n < 100 && download_busy !== 1'b0; n++)
			@(posedge clk);
		tmo(n);
	endtask

	// sel picks the erase half of the rom
	task automatic words(input logic [7:0] dest, input logic sel);
		for (k = 0; k < 16; k++)
			chk(mem.ram[{dest, 4'(k)}], 32'hc0de0000 | {sel, 4'(k)});
	endtask

	// ************************************************
	// scenarios
	// ************************************************
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1;
		for (i = 0; i < 6; i++)
			rchk(8'(i * 4), 0);
		rd(8'h20);
		chk(32'(r), 32'(RESP_SLVERR));
		wr(8'h20, 32'h00);
		chk(32'(b), 32'(RESP_SLVERR));
		// ram vector table taken as already loaded
		wr(8'h00, 32'h08);
		chk(32'(b), 32'(RESP_OKAY));
		rchk(8'h00, 32'h08);
		chk(32'(vector_relocate_enable), 1);
		vchk(24'h00007c, 24'hffe0fc);
		vchk(24'h000000, 24'hffe080);
		vchk(24'h000080, 24'h000080);
		wr(8'h00, 32'h00);
		vchk(24'h00007c, 24'h00007c);
		// no vector fetches from here on
		wr(8'h04, 32'h01);
		wr(8'h0c, 32'h12);
		exec_from_ram <= 1;
		wr(8'h00, 32'h01);
		repeat (4) @(posedge clk);
		chk(32'(download_busy), 0);
		wr(8'h10, 32'ha5);
		exec_from_ram <= 0;
		wr(8'h00, 32'h01);
		repeat (4) @(posedge clk);
		chk(32'(download_busy), 0);
		rchk(8'h04, 1);
		rchk(8'h0c, 32'h12);
		chk(32'(mem.n_wr), 0);
		// lane 0 disabled: the write must change nothing
		s_axi_wstrb <= 4'he;
		wr(8'h0c, 32'h55);
		s_axi_wstrb <= 4'hf;
		rchk(8'h0c, 32'h12);
		exec_from_ram <= 1;
		wr(8'h00, 32'h01);
		repeat (4) @(posedge clk);
		rchk(8'h14, 1);
		rchk(8'h00, 0);
		idle_wait;
		chk(32'(mem.n_wr), 16);
		rchk(8'h04, 0);
		words(8'h12, 1'b0);
		wr(8'h08, 32'h01);
		wr(8'h0c, 32'h34);
		wr(8'h00, 32'h01);
		repeat (4) @(posedge clk);
		idle_wait;
		rchk(8'h08, 0);
		words(8'h34, 1'b1);
		wr(8'h00, 32'h01);
		repeat (4) @(posedge clk);
		idle_wait;
		chk(32'(mem.n_wr), 32);
		wrap_up;
	end
endmodule
`default_nettype wire
